// *** rtl/chgi_pkg.sv ***
/*
 package for the charger serial register port: addresses, register
 indexes, reset values and timing counts. assumes sys_clk at 200 mhz.
*/
`default_nettype none
package chgi_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h6b;
    localparam int CLK_MHZ = 200;
    localparam logic [7:0] IDX_OPT_A = 8'h00;
    localparam logic [7:0] IDX_CHG_CUR = 8'h02;
    localparam logic [7:0] IDX_MAX_V = 8'h04;
    localparam logic [7:0] IDX_IIN_USE = 8'h24;
    localparam logic [7:0] IDX_REV_V = 8'h06;
    localparam logic [7:0] IDX_IN_V = 8'h0a;
    localparam logic [7:0] IDX_MAKER = 8'h2e;
    localparam logic [7:0] IDX_PART = 8'h2f;
    localparam logic [7:0] IDX_OPT_B = 8'h30;
    localparam logic [7:0] IDX_OPT_C = 8'h32;
    localparam logic [7:0] IDX_OPT_D = 8'h34;
    localparam logic [15:0] RST_OPT_A = 16'he60e;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_MAX_V = 16'h1068;
    localparam logic [15:0] CHG_CUR_MASK = 16'h1fc0;
    localparam logic [15:0] MAX_V_MASK = 16'h7ff8;
    localparam int WDT_FIELD_LO = 13;
    localparam int WDT_S_5 = 5;
    localparam int WDT_S_88 = 88;
    localparam int WDT_S_175 = 175;
    localparam int SEC_DIV_CYC = CLK_MHZ * 1000000;
    typedef enum logic [2:0] {
        CHGI_IDLE = 3'b000,
        CHGI_ADDR = 3'b001,
        CHGI_INDEX = 3'b011,
        CHGI_WDATA = 3'b010,
        CHGI_RDATA = 3'b110,
        CHGI_IGNORE = 3'b111
    } chgi_state_t;
endpackage : chgi_pkg
`default_nettype wire

// *** rtl/chgi_sync.sv ***
/*
 two-flop synchroniser with edge flags for scl and sda.
 assumes pins are asynchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module chgi_sync (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_s,
    output logic sda_s,
    output logic scl_rise,
    output logic scl_fall,
    output logic sda_rise,
    output logic sda_fall
);
    logic [1:0] m_r, m_nxt, s_r, s_nxt, p_r, p_nxt;
    always_comb begin
        m_nxt = {scl_in, sda_in};
        s_nxt = m_r;
        p_nxt = s_r;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            m_r <= 2'b11;
            s_r <= 2'b11;
            p_r <= 2'b11;
        end else begin
            m_r <= m_nxt;
            s_r <= s_nxt;
            p_r <= p_nxt;
        end
    end
    assign scl_s = s_r[1];
    assign sda_s = s_r[0];
    assign scl_rise = s_r[1] & ~p_r[1];
    assign scl_fall = ~s_r[1] & p_r[1];
    assign sda_rise = s_r[0] & ~p_r[0];
    assign sda_fall = ~s_r[0] & p_r[0];
endmodule : chgi_sync
`default_nettype wire

// *** rtl/chgi_port.sv ***
/*
 i2c slave register port of the charge controller with paired
 register commit and watchdog expiry. assumes external pull-ups and
 a master that drives scl; sys_clk 200 mhz.
*/
`timescale 1ns/100ps
`default_nettype none
module chgi_port #(
    parameter logic [7:0] PART_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
    parameter int SEC_CYC = chgi_pkg::SEC_DIV_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    input wire logic [15:0] input_current_limit_in_use,
    output logic [15:0] charge_option_a,
    output logic [15:0] charge_current_setting,
    output logic [15:0] max_charge_voltage_setting,
    output logic [15:0] reverse_output_voltage_setting,
    output logic [15:0] input_voltage_setting,
    output logic [15:0] charge_option_b,
    output logic [15:0] charge_option_c,
    output logic [15:0] charge_option_d,
    output logic bus_busy,
    output logic watchdog_expired
);
    logic scl_s, sda_s, scl_rise, scl_fall, sda_rise, sda_fall;
    chgi_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .sda_rise(sda_rise),
        .sda_fall(sda_fall)
    );
    function automatic logic defined_idx(input logic [7:0] i);
        case (i)
            chgi_pkg::IDX_OPT_A, chgi_pkg::IDX_OPT_A + 8'h01,
            chgi_pkg::IDX_CHG_CUR, chgi_pkg::IDX_CHG_CUR + 8'h01,
            chgi_pkg::IDX_MAX_V, chgi_pkg::IDX_MAX_V + 8'h01,
            chgi_pkg::IDX_REV_V, chgi_pkg::IDX_REV_V + 8'h01,
            chgi_pkg::IDX_IN_V, chgi_pkg::IDX_IN_V + 8'h01,
            chgi_pkg::IDX_IIN_USE, chgi_pkg::IDX_IIN_USE + 8'h01,
            chgi_pkg::IDX_MAKER, chgi_pkg::IDX_PART,
            chgi_pkg::IDX_OPT_B, chgi_pkg::IDX_OPT_B + 8'h01,
            chgi_pkg::IDX_OPT_C, chgi_pkg::IDX_OPT_C + 8'h01,
            chgi_pkg::IDX_OPT_D, chgi_pkg::IDX_OPT_D + 8'h01:
                defined_idx = 1'b1;
            default: defined_idx = 1'b0;
        endcase
    endfunction : defined_idx
    function automatic logic is_paired(input logic [7:0] i);
        is_paired = (i == chgi_pkg::IDX_CHG_CUR) ||
            (i == chgi_pkg::IDX_MAX_V) || (i == chgi_pkg::IDX_REV_V) ||
            (i == chgi_pkg::IDX_IN_V) || (i == chgi_pkg::IDX_IIN_USE);
    endfunction : is_paired
    chgi_pkg::chgi_state_t st_r, st_nxt;
    logic [7:0] sh_r, sh_nxt, idx_r, idx_nxt, tx_r, tx_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic idx_ok_r, idx_ok_nxt, ack_r, ack_nxt, busy_r, busy_nxt;
    logic sda_o_r, sda_o_nxt, nack_r, nack_nxt;
    logic [15:0] opt_a_r, opt_a_nxt, cur_r, cur_nxt, mv_r, mv_nxt;
    logic [15:0] rv_r, rv_nxt, iv_r, iv_nxt, iiu_r;
    logic [15:0] ob_r, ob_nxt, oc_r, oc_nxt, od_r, od_nxt;
    logic [7:0] pend_r, pend_nxt, pidx_r, pidx_nxt;
    logic pvld_r, pvld_nxt, wexp_r, wexp_nxt;
    logic [31:0] div_r, div_nxt;
    logic [7:0] sec_r, sec_nxt, psec_r, psec_nxt;
    logic [7:0] wdt_lim;
    logic [7:0] rd_byte;
    logic wstb;
    always_comb begin
        case (opt_a_r[chgi_pkg::WDT_FIELD_LO +: 2])
            2'b01: wdt_lim = 8'(chgi_pkg::WDT_S_5);
            2'b10: wdt_lim = 8'(chgi_pkg::WDT_S_88);
            2'b11: wdt_lim = 8'(chgi_pkg::WDT_S_175);
            default: wdt_lim = 8'h00;
        endcase
        case (idx_r)
            chgi_pkg::IDX_OPT_A: rd_byte = opt_a_r[7:0];
            chgi_pkg::IDX_OPT_A + 8'h01: rd_byte = opt_a_r[15:8];
            chgi_pkg::IDX_CHG_CUR: rd_byte = cur_r[7:0];
            chgi_pkg::IDX_CHG_CUR + 8'h01: rd_byte = cur_r[15:8];
            chgi_pkg::IDX_MAX_V: rd_byte = mv_r[7:0];
            chgi_pkg::IDX_MAX_V + 8'h01: rd_byte = mv_r[15:8];
            chgi_pkg::IDX_REV_V: rd_byte = rv_r[7:0];
            chgi_pkg::IDX_REV_V + 8'h01: rd_byte = rv_r[15:8];
            chgi_pkg::IDX_IN_V: rd_byte = iv_r[7:0];
            chgi_pkg::IDX_IN_V + 8'h01: rd_byte = iv_r[15:8];
            chgi_pkg::IDX_IIN_USE: rd_byte = iiu_r[7:0];
            chgi_pkg::IDX_IIN_USE + 8'h01: rd_byte = iiu_r[15:8];
            chgi_pkg::IDX_MAKER: rd_byte = MAKER_CODE;
            chgi_pkg::IDX_PART: rd_byte = PART_CODE;
            chgi_pkg::IDX_OPT_B: rd_byte = ob_r[7:0];
            chgi_pkg::IDX_OPT_B + 8'h01: rd_byte = ob_r[15:8];
            chgi_pkg::IDX_OPT_C: rd_byte = oc_r[7:0];
            chgi_pkg::IDX_OPT_C + 8'h01: rd_byte = oc_r[15:8];
            chgi_pkg::IDX_OPT_D: rd_byte = od_r[7:0];
            chgi_pkg::IDX_OPT_D + 8'h01: rd_byte = od_r[15:8];
            default: rd_byte = 8'h00;
        endcase
    end
    // bus state machine
    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        idx_nxt = idx_r;
        tx_nxt = tx_r;
        bit_nxt = bit_r;
        idx_ok_nxt = idx_ok_r;
        ack_nxt = ack_r;
        busy_nxt = busy_r;
        sda_o_nxt = sda_o_r;
        nack_nxt = nack_r;
        wstb = 1'b0;
        if (scl_s && sda_fall) begin
            busy_nxt = 1'b1;
            st_nxt = chgi_pkg::CHGI_ADDR;
            bit_nxt = 4'h0;
            idx_ok_nxt = 1'b0;
            sda_o_nxt = 1'b0;
            ack_nxt = 1'b0;
        end else if (scl_s && sda_rise) begin
            busy_nxt = 1'b0;
            st_nxt = chgi_pkg::CHGI_IDLE;
            sda_o_nxt = 1'b0;
        end else if (st_r != chgi_pkg::CHGI_IDLE &&
                st_r != chgi_pkg::CHGI_IGNORE) begin
            if (scl_rise) begin
                if (bit_r < 4'd8) begin
                    sh_nxt = {sh_r[6:0], sda_s};
                    bit_nxt = bit_r + 4'd1;
                end else begin
                    nack_nxt = sda_s;
                end
            end else if (scl_fall) begin
                if (bit_r == 4'd8 && !ack_r) begin
                    ack_nxt = 1'b1;
                    sda_o_nxt = 1'b0;
                    case (st_r)
                        chgi_pkg::CHGI_ADDR: begin
                            if (sh_r[7:1] == chgi_pkg::SLAVE_ADDR) begin
                                sda_o_nxt = 1'b1;
                                st_nxt = sh_r[0] ? chgi_pkg::CHGI_RDATA
                                    : chgi_pkg::CHGI_INDEX;
                            end else begin
                                st_nxt = chgi_pkg::CHGI_IGNORE;
                            end
                        end
                        chgi_pkg::CHGI_INDEX: begin
                            idx_nxt = sh_r;
                            if (defined_idx(sh_r)) begin
                                sda_o_nxt = 1'b1;
                                idx_ok_nxt = 1'b1;
                                st_nxt = chgi_pkg::CHGI_WDATA;
                            end else begin
                                st_nxt = chgi_pkg::CHGI_IGNORE;
                            end
                        end
                        chgi_pkg::CHGI_WDATA: begin
                            sda_o_nxt = 1'b1;
                            wstb = 1'b1;
                            idx_nxt = idx_r + 8'h01;
                        end
                        default: sda_o_nxt = 1'b0;
                    endcase
                end else if (bit_r == 4'd8) begin
                    // ninth clock over: release sda or drive next read byte's msb, start next byte
                    bit_nxt = 4'h0;
                    ack_nxt = 1'b0;
                    sda_o_nxt = 1'b0;
                    if (st_r == chgi_pkg::CHGI_RDATA) begin
                        if (nack_r) begin
                            st_nxt = chgi_pkg::CHGI_IGNORE;
                        end else begin
                            if (idx_ok_r) begin
                                idx_nxt = idx_r + 8'h01;
                            end
                            tx_nxt = rd_byte;
                            sda_o_nxt = ~rd_byte[7];
                        end
                    end
                end else if (st_r == chgi_pkg::CHGI_RDATA) begin
                    sda_o_nxt = ~tx_r[3'(7 - bit_r)];
                end
            end
        end
        if (st_r == chgi_pkg::CHGI_ADDR && st_nxt == chgi_pkg::CHGI_RDATA) begin
            idx_ok_nxt = 1'b1;
        end
    end
    // register file with paired commit
    always_comb begin
        opt_a_nxt = opt_a_r;
        cur_nxt = cur_r;
        mv_nxt = mv_r;
        rv_nxt = rv_r;
        iv_nxt = iv_r;
        ob_nxt = ob_r;
        oc_nxt = oc_r;
        od_nxt = od_r;
        pend_nxt = pend_r;
        pidx_nxt = pidx_r;
        pvld_nxt = pvld_r;
        wexp_nxt = wexp_r;
        div_nxt = div_r + 32'd1;
        sec_nxt = sec_r;
        psec_nxt = psec_r;
        if (div_r >= 32'(SEC_CYC - 1)) begin
            div_nxt = 32'd0;
            if (sec_r != 8'hff) begin
                sec_nxt = sec_r + 8'h01;
            end
            if (pvld_r && psec_r != 8'hff) begin
                psec_nxt = psec_r + 8'h01;
            end
        end
        if (wdt_lim != 8'h00 && sec_r >= wdt_lim) begin
            wexp_nxt = 1'b1;
            cur_nxt = chgi_pkg::RST_ZERO;
        end
        if (wdt_lim == 8'h00) begin
            wexp_nxt = 1'b0;
        end
        if (pvld_r && wdt_lim != 8'h00 && psec_r >= wdt_lim) begin
            pvld_nxt = 1'b0;
        end
        if (wstb) begin
            if (is_paired(idx_r)) begin
                pend_nxt = sh_r;
                pidx_nxt = idx_r;
                pvld_nxt = 1'b1;
                psec_nxt = 8'h00;
            end else if (pvld_r && idx_r == pidx_r + 8'h01 &&
                    !(wdt_lim != 8'h00 && psec_r >= wdt_lim)) begin
                pvld_nxt = 1'b0;
                case (pidx_r)
                    chgi_pkg::IDX_CHG_CUR: begin
                        cur_nxt = {sh_r, pend_r} & chgi_pkg::CHG_CUR_MASK;
                        sec_nxt = 8'h00;
                        wexp_nxt = 1'b0;
                    end
                    chgi_pkg::IDX_MAX_V: begin
                        mv_nxt = {sh_r, pend_r} & chgi_pkg::MAX_V_MASK;
                        sec_nxt = 8'h00;
                        wexp_nxt = 1'b0;
                    end
                    chgi_pkg::IDX_REV_V: rv_nxt = {sh_r, pend_r};
                    chgi_pkg::IDX_IN_V: iv_nxt = {sh_r, pend_r};
                    default: pvld_nxt = 1'b0;
                endcase
            end else begin
                pvld_nxt = 1'b0;
                case (idx_r)
                    chgi_pkg::IDX_OPT_A: opt_a_nxt[7:0] = sh_r;
                    chgi_pkg::IDX_OPT_A + 8'h01: opt_a_nxt[15:8] = sh_r;
                    chgi_pkg::IDX_OPT_B: ob_nxt[7:0] = sh_r;
                    chgi_pkg::IDX_OPT_B + 8'h01: ob_nxt[15:8] = sh_r;
                    chgi_pkg::IDX_OPT_C: oc_nxt[7:0] = sh_r;
                    chgi_pkg::IDX_OPT_C + 8'h01: oc_nxt[15:8] = sh_r;
                    chgi_pkg::IDX_OPT_D: od_nxt[7:0] = sh_r;
                    chgi_pkg::IDX_OPT_D + 8'h01: od_nxt[15:8] = sh_r;
                    default: pvld_nxt = 1'b0;
                endcase
            end
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= chgi_pkg::CHGI_IDLE;
            sh_r <= 8'h00;
            idx_r <= 8'h00;
            tx_r <= 8'h00;
            bit_r <= 4'h0;
            idx_ok_r <= 1'b0;
            ack_r <= 1'b0;
            busy_r <= 1'b0;
            sda_o_r <= 1'b0;
            nack_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            idx_r <= idx_nxt;
            tx_r <= tx_nxt;
            bit_r <= bit_nxt;
            idx_ok_r <= idx_ok_nxt;
            ack_r <= ack_nxt;
            busy_r <= busy_nxt;
            sda_o_r <= sda_o_nxt;
            nack_r <= nack_nxt;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            opt_a_r <= chgi_pkg::RST_OPT_A;
            cur_r <= chgi_pkg::RST_ZERO;
            mv_r <= chgi_pkg::RST_MAX_V;
            rv_r <= chgi_pkg::RST_ZERO;
            iv_r <= chgi_pkg::RST_ZERO;
            ob_r <= chgi_pkg::RST_ZERO;
            oc_r <= chgi_pkg::RST_ZERO;
            od_r <= chgi_pkg::RST_ZERO;
            pend_r <= 8'h00;
            pidx_r <= 8'h00;
            pvld_r <= 1'b0;
            wexp_r <= 1'b0;
            div_r <= 32'd0;
            sec_r <= 8'h00;
            psec_r <= 8'h00;
            iiu_r <= chgi_pkg::RST_ZERO;
        end else begin
            opt_a_r <= opt_a_nxt;
            cur_r <= cur_nxt;
            mv_r <= mv_nxt;
            rv_r <= rv_nxt;
            iv_r <= iv_nxt;
            ob_r <= ob_nxt;
            oc_r <= oc_nxt;
            od_r <= od_nxt;
            pend_r <= pend_nxt;
            pidx_r <= pidx_nxt;
            pvld_r <= pvld_nxt;
            wexp_r <= wexp_nxt;
            div_r <= div_nxt;
            sec_r <= sec_nxt;
            psec_r <= psec_nxt;
            iiu_r <= input_current_limit_in_use;
        end
    end
    // open drain: the port never drives high and never stretches scl
    assign sda_out = 1'b0;
    assign sda_oe = sda_o_r;
    assign scl_out = 1'b0;
    assign scl_oe = 1'b0;
    assign charge_option_a = opt_a_r;
    assign charge_current_setting = cur_r;
    assign max_charge_voltage_setting = mv_r;
    assign reverse_output_voltage_setting = rv_r;
    assign input_voltage_setting = iv_r;
    assign charge_option_b = ob_r;
    assign charge_option_c = oc_r;
    assign charge_option_d = od_r;
    assign bus_busy = busy_r;
    assign watchdog_expired = wexp_r;
endmodule : chgi_port
`default_nettype wire

// *** tb/chgi_port_assertions.sv ***
/*
 checker for the charger register port pins and paired settings.
 bound to chgi_port; sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module chgi_port_assertions (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic [15:0] charge_current_setting,
    input wire logic [15:0] max_charge_voltage_setting,
    input wire logic bus_busy
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_start;
        $fell(sda_in) && scl_in && $past(scl_in);
    endsequence
    sequence s_stop;
        $rose(sda_in) && scl_in && $past(scl_in);
    endsequence
    a_busy_on_start: assert property (s_start |-> ##[1:6] bus_busy)
        else $error("busy missing after start");
    a_free_on_stop: assert property (s_stop |-> ##[1:6] !bus_busy)
        else $error("busy kept after stop");
    a_busy_end_cause: assert property ($fell(bus_busy) |-> sda_in && scl_in)
        else $error("busy dropped without stop");
    a_busy_rise_cause: assert property ($rose(bus_busy) |-> !sda_in)
        else $error("busy raised without start");
    a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda moved while scl high");
    a_ack_held_high: assert property (sda_oe && scl_in |=> sda_oe)
        else $error("sda released during high phase");
    a_no_stretch: assert property (scl_oe == 1'b0)
        else $error("scl held low");
    a_drive_low_only: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin driven high");
    a_cur_field: assert property ((charge_current_setting & 16'he03f) == 16'h0000)
        else $error("charge current outside field");
    a_volt_field: assert property ((max_charge_voltage_setting & 16'h8007) == 16'h0000)
        else $error("voltage outside field");
    a_volt_one_step: assert property ($changed(max_charge_voltage_setting)
        |=> $stable(max_charge_voltage_setting) [*8])
        else $error("voltage updated in steps");
endmodule : chgi_port_assertions
bind chgi_port chgi_port_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_out(scl_out), .scl_oe(scl_oe), .bus_busy(bus_busy),
    .charge_current_setting(charge_current_setting),
    .max_charge_voltage_setting(max_charge_voltage_setting));
`default_nettype wire

// *** tb/chgi_host.sv ***
/*
 bus master model: start, stop and bytes at 16 clocks per bit.
 assumes sys_clk 200 mhz and a pulled-up sda wire.
*/
`timescale 1ns/100ps
`default_nettype none
module chgi_host (
    input wire logic sys_clk,
    input wire logic sda,
    output logic scl_r,
    output logic sda_r
);
    initial begin
        scl_r = 1'b1;
        sda_r = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hw
    task automatic bit_io(input logic b, output logic q);
        hw(4);
        sda_r <= b;
        hw(4);
        scl_r <= 1'b1;
        hw(4);
        q = sda;
        hw(4);
        scl_r <= 1'b0;
    endtask : bit_io
    task automatic byte_io(input logic [7:0] d, input logic ak,
                           output logic [7:0] q, output logic aq);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ak, aq);
    endtask : byte_io
    task automatic start;
        hw(4);
        sda_r <= 1'b1;
        hw(4);
        scl_r <= 1'b1;
        hw(4);
        sda_r <= 1'b0;
        hw(4);
        scl_r <= 1'b0;
    endtask : start
    task automatic stop;
        hw(4);
        sda_r <= 1'b0;
        hw(4);
        scl_r <= 1'b1;
        hw(4);
        sda_r <= 1'b1;
        hw(8);
    endtask : stop
endmodule : chgi_host
`default_nettype wire

// *** tb/charger_i2c_register_port_tb.sv ***
/*
 self-checking bench for the charger register port.
 assumes chgi_host as master and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module charger_i2c_register_port_tb;
    localparam logic [7:0] MK = 8'h3c; // arbitrary value
    logic sys_clk, nrst, sda_oe, scl_oe, bus_busy, watchdog_expired;
    logic host_scl, host_sda;
    logic [15:0] input_current_limit_in_use, charge_option_a, charge_option_b;
    logic [15:0] charge_current_setting, max_charge_voltage_setting, v;
    logic [15:0] rev_v, in_v, opt_c, opt_d;
    wire scl = host_scl & ~scl_oe;
    wire sda = host_sda & ~sda_oe;
    int failures = 0;
    int checks_done = 0;
    chgi_host host (.sys_clk(sys_clk), .sda(sda), .scl_r(host_scl),
        .sda_r(host_sda));
    chgi_port #(.MAKER_CODE(MK), .SEC_CYC(100)) DUT (
        .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .scl_out(), .scl_oe(scl_oe),
        .input_current_limit_in_use(input_current_limit_in_use),
        .charge_option_a(charge_option_a),
        .charge_current_setting(charge_current_setting),
        .max_charge_voltage_setting(max_charge_voltage_setting),
        .reverse_output_voltage_setting(rev_v), .input_voltage_setting(in_v),
        .charge_option_b(charge_option_b), .charge_option_c(opt_c),
        .charge_option_d(opt_d), .bus_busy(bus_busy),
        .watchdog_expired(watchdog_expired));
    always #2.5 sys_clk = ~sys_clk;
    task automatic test_done;
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [7:0] ix, input int n,
                      input logic [15:0] d, input logic ea);
        logic [7:0] q;
        logic a;
        host.start();
        host.byte_io(ad, 1'b1, q, a);
        chk("busy", 16'h0001, {15'h0000, bus_busy});
        if (a === 1'b0) begin
            host.byte_io(ix, 1'b1, q, a);
            for (int i = 0; i < n && a === 1'b0; i++)
                host.byte_io(d[8*i+:8], 1'b1, q, a);
        end
        chk("ack", {15'h0000, ea}, {15'h0000, a});
        host.stop();
        chk("free", 16'h0000, {15'h0000, bus_busy});
    endtask : wr
    task automatic rd(input logic [7:0] ix, input int n, output logic [15:0] d);
        logic [7:0] q;
        logic a;
        host.start();
        host.byte_io(8'hd6, 1'b1, q, a);
        host.byte_io(ix, 1'b1, q, a);
        host.start();
        host.byte_io(8'hd7, 1'b1, q, a);
        d = 16'h0000;
        for (int i = 0; i < n; i++) begin
            host.byte_io(8'hff, i == n - 1, q, a);
            d[8*i+:8] = q;
        end
        host.stop();
    endtask : rd
    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        test_done();
    end
    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        input_current_limit_in_use = 16'h1234;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("opt_a", 16'he60e, charge_option_a);
        chk("max_v", 16'h1068, max_charge_voltage_setting);
        chk("cur", 16'h0000, charge_current_setting);
        wr(8'hd6, 8'h30, 2, 16'h5aa5, 1'b0);
        chk("opt_b", 16'h5aa5, charge_option_b);
        rd(8'h30, 2, v);
        chk("opt_b_rd", 16'h5aa5, v);
        wr(8'hd4, 8'h30, 2, 16'h1111, 1'b1);
        wr(8'hd6, 8'h10, 1, 16'h0077, 1'b1);
        chk("opt_b", 16'h5aa5, charge_option_b);
        rd(8'h2e, 1, v);
        chk("maker", {8'h00, MK}, v);
        wr(8'hd6, 8'h02, 1, 16'h00c0, 1'b0);
        chk("lo_pend", 16'h0000, charge_current_setting);
        wr(8'hd6, 8'h03, 1, 16'h00ff, 1'b0);
        chk("commit", 16'h1fc0, charge_current_setting);
        wr(8'hd6, 8'h03, 1, 16'h0001, 1'b0);
        chk("lone_hi", 16'h1fc0, charge_current_setting);
        wr(8'hd6, 8'h06, 2, 16'h1234, 1'b0);
        chk("rev_v", 16'h1234, rev_v);
        wr(8'hd6, 8'h0a, 2, 16'h00c8, 1'b0);
        chk("in_v", 16'h00c8, in_v);
        wr(8'hd6, 8'h32, 2, 16'hbeef, 1'b0);
        chk("opt_c", 16'hbeef, opt_c);
        wr(8'hd6, 8'h34, 2, 16'hcafe, 1'b0);
        chk("opt_d", 16'hcafe, opt_d);
        wr(8'hd6, 8'h04, 2, 16'hffff, 1'b0);
        rd(8'h04, 2, v);
        chk("max_v_rd", 16'h7ff8, v);
        rd(8'h24, 2, v);
        chk("iin_rd", 16'h1234, v);
        wr(8'hd6, 8'h00, 2, 16'ha60e, 1'b0);
        wr(8'hd6, 8'h04, 1, 16'h0008, 1'b0);
        repeat (700) @(posedge sys_clk);
        chk("wdt", 16'h0001, {15'h0000, watchdog_expired});
        chk("wdt_cur", 16'h0000, charge_current_setting);
        wr(8'hd6, 8'h05, 1, 16'h0010, 1'b0);
        chk("expired", 16'h7ff8, max_charge_voltage_setting);
        test_done();
    end
endmodule : charger_i2c_register_port_tb
`default_nettype wire
